/* plrc_pkg.sv */
// package: constants and types shared by both ends of the pll reset/calibration link
package plrc_pkg;
  // register indices in the device bank
  localparam logic [7:0]  REG_SOFT_RESET   = 8'h0C;
  localparam logic [7:0]  REG_CP_CURRENT   = 8'h39;
  localparam logic [7:0]  REG_DSM_CFG      = 8'h42;
  localparam logic [7:0]  REG_LF_R2        = 8'h43;
  localparam logic [7:0]  REG_LF_C1        = 8'h44;
  localparam logic [7:0]  REG_LF_R3        = 8'h45;
  localparam logic [7:0]  REG_LF_C3        = 8'h46;
  localparam logic [7:0]  REG_LOOP_ORDER   = 8'h76;
  localparam logic [7:0]  REG_LOW_BW       = 8'h78;
  localparam logic [7:0]  REG_AUTO_MUTE    = 8'h16;
  localparam logic [7:0]  REG_DEN_LO       = 8'h3F;
  localparam logic [7:0]  REG_DEN_MID      = 8'h40;
  localparam logic [7:0]  REG_DEN_HI       = 8'h41;
  // field positions
  localparam int          SOFT_RESET_POS   = 7;
  localparam int          LF_MODE_POS      = 0;
  localparam int          LOW_BW_POS       = 0;
  // reset / pin-mode default values
  localparam logic [7:0]  DEF_SOFT_RESET   = 8'h80;
  localparam logic [7:0]  DEF_CP_CURRENT   = 8'h04;
  localparam logic [7:0]  DEF_DSM_CFG      = 8'h03;
  localparam logic [7:0]  DEF_LF           = 8'h00;
  localparam logic [7:0]  DEF_LOOP_ORDER   = 8'h07;
  localparam logic [7:0]  DEF_LOW_BW       = 8'h01;
  localparam logic [7:0]  DEF_AUTO_MUTE    = 8'hFF;
  localparam logic [7:0]  DEF_DEN_LO       = 8'h01;
  localparam logic [7:0]  DEF_DEN_MID      = 8'h00;
  localparam logic [7:0]  DEF_DEN_HI       = 8'h00;
  // recommended host settings
  localparam logic [2:0]  LOOP_ORDER_THIRD  = 3'h7;
  localparam logic [2:0]  LOOP_ORDER_SECOND = 3'h3;
  localparam logic [21:0] DEN_MAX           = 22'h3F_FFFF;
  localparam logic [21:0] DEN_DITHER_MIN    = 22'h00_0014;
  localparam logic [21:0] DEN_DITHER_GOOD   = 22'h00_00C8;
  // timing
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          RESET_TIMER_NS   = 4000;
  localparam int          RESET_TIMER_CYC  = (RESET_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CAL_TIME_NS      = 400;
  localparam int          CAL_CYC          = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  PIN_SYNC_INIT    = 2'h3;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_LOAD   = 3'b001,
    ST_STAB   = 3'b010,
    ST_CAL    = 3'b011,
    ST_LOCK   = 3'b100,
    ST_RUN    = 3'b101
  } plrc_state_t;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_WRITE  = 2'b01,
    HS_WAIT   = 2'b10
  } plrc_hstate_t;
endpackage : plrc_pkg

/* plrc_link_if.sv */
// interface: power-down pin and register write/read port between host and device
`timescale 1ns/1ps
`default_nettype none
interface plrc_link_if;
  logic       powerdown_n_pin;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       rd_valid;

  modport dev (
    input  powerdown_n_pin,
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data,
    output rd_valid
  );
  modport host (
    output powerdown_n_pin,
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data,
    input  rd_valid
  );
endinterface : plrc_link_if
`default_nettype wire

/* plrc_device.sv */
// device end: register bank, reset sequencing, vco calibration and auto-mute
// Notes on behaviour
// [R1] 4-bit charge pump select, 0.4 to 6.4 mA
// [R2] four registers set loop filter R2,C1,R3,C3
// [R3] fractional: filter mode 1, loop order 0x7
// [R4] integer: mode 0, order 0x3 or 0x7
// [R5] 200 Hz bandwidth: clear low-bandwidth bit
// [R6] pin low or soft bit zero enters reset
// [R7] reset exits on power-up or rising source
// [R8] pin exit reloads pin-mode defaults
// [R9] soft reset keeps registers, calibrates current plan
// [R10] soft bit reads high; write low then high
// [R11] wait supply good and timer before calibration
// [R12] mute auto-mute outputs while calibrating
// [R13] after calibration, lock to reference
// [R14] two-bit modulator order, integer to third
// [R15] two-bit dither mode beside order field
// [R16] host disables dither for poor denominators
// [R17] divide is int plus num over den
// [R18] reset timer parameter; reset restarts calibration
// [R19] unmute only after calibration and lock
`timescale 1ns/1ps
`default_nettype none
module plrc_device
  import plrc_pkg::*;
#(
  parameter int RESET_TIMER_CYCLES = RESET_TIMER_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  // link
  plrc_link_if.dev        link,
  // analog status
  input  wire logic       supply_ok_i,
  input  wire logic       pll_locked_i,
  // control to pll and outputs
  output logic [3:0]      charge_pump_current_sel_o,
  output logic            loop_filter_mode_bit_o,
  output logic [7:0]      lf_r2_o,
  output logic [7:0]      lf_c1_o,
  output logic [7:0]      lf_r3_o,
  output logic [7:0]      lf_c3_o,
  output logic [2:0]      loop_order_cfg_o,
  output logic            low_bandwidth_ctrl_o,
  output logic [1:0]      modulator_order_sel_o,
  output logic [1:0]      dither_mode_sel_o,
  output logic [21:0]     fraction_denominator_o,
  output logic [7:0]      output_mute_o,
  output logic            vco_cal_busy_o,
  output logic            lock_enable_o,
  output logic            pll_ready_o
);
  // three-stage pin synchroniser; second and third agreeing qualify a change
  logic [2:0]  pin_sync_reg;
  logic        pin_level_reg;
  logic        pin_rise;
  logic        pin_fall;

  logic [7:0]  soft_reset_reg;
  logic [7:0]  cp_reg;
  logic [7:0]  dsm_reg;
  logic [7:0]  lf_reg [4];
  logic [7:0]  order_reg;
  logic [7:0]  lowbw_reg;
  logic [7:0]  mute_en_reg;
  logic [7:0]  den_reg [3];
  logic [7:0]  rd_data_reg;
  logic        rd_valid_reg;

  plrc_state_t state_reg;
  plrc_state_t state_next;
  logic [31:0] cnt_reg;
  logic        reload_reg;

  wire         pin_agree   = (pin_sync_reg[1] == pin_sync_reg[2]);
  wire         soft_low    = ~soft_reset_reg[SOFT_RESET_POS];
  wire         in_reset    = ~pin_level_reg | soft_low;  // [R6]
  wire         timer_done  = (cnt_reg >= 32'(RESET_TIMER_CYCLES));
  wire         cal_done    = (cnt_reg >= 32'(CAL_CYC));
  wire         load_pulse  = (state_reg == ST_LOAD) & reload_reg;
  wire [21:0]  den_raw     = {den_reg[2][5:0], den_reg[1], den_reg[0]};

  assign pin_rise = pin_agree & pin_sync_reg[1] & ~pin_level_reg;
  assign pin_fall = pin_agree & ~pin_sync_reg[1] & pin_level_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync_reg  <= {PIN_SYNC_INIT, 1'b1};
      pin_level_reg <= 1'b1;
    end else if (clk_en_i) begin
      pin_sync_reg  <= {pin_sync_reg[1:0], link.powerdown_n_pin};
      if (pin_rise || pin_fall) begin
        pin_level_reg <= pin_sync_reg[1];
      end
    end
  end

  // sequencer: power-up (rst_i release) starts like a pin exit
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: if (!in_reset) state_next = ST_LOAD;          // [R7]
      ST_LOAD:  state_next = ST_STAB;
      ST_STAB:  if (supply_ok_i && timer_done) state_next = ST_CAL; // [R11]
      ST_CAL:   if (cal_done) state_next = ST_LOCK;
      ST_LOCK:  if (pll_locked_i) state_next = ST_RUN;         // [R13]
      ST_RUN:   state_next = ST_RUN;
      default:  state_next = ST_RESET;
    endcase
    if (in_reset) state_next = ST_RESET;                       // [R18]
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg  <= ST_RESET;
      cnt_reg    <= '0;
      reload_reg <= 1'b1;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + 32'd1;
      // pin entry arms a reload; soft-only entry keeps the bank
      if (!pin_level_reg) begin
        reload_reg <= 1'b1;                                    // [R8]
      end else if (state_reg == ST_LOAD) begin
        reload_reg <= 1'b0;                                    // [R9]
      end
    end
  end

  // register bank; pin-exit load restores defaults, the soft reset register included
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_reg <= DEF_SOFT_RESET;
      cp_reg         <= DEF_CP_CURRENT;
      dsm_reg        <= DEF_DSM_CFG;
      lf_reg         <= '{DEF_LF, DEF_LF, DEF_LF, DEF_LF};
      order_reg      <= DEF_LOOP_ORDER;
      lowbw_reg      <= DEF_LOW_BW;
      mute_en_reg    <= DEF_AUTO_MUTE;
      den_reg        <= '{DEF_DEN_LO, DEF_DEN_MID, DEF_DEN_HI};
    end else if (clk_en_i) begin
      if (load_pulse) begin
        soft_reset_reg <= DEF_SOFT_RESET;                      // [R8]
        cp_reg         <= DEF_CP_CURRENT;
        dsm_reg        <= DEF_DSM_CFG;
        lf_reg         <= '{DEF_LF, DEF_LF, DEF_LF, DEF_LF};
        order_reg      <= DEF_LOOP_ORDER;
        lowbw_reg      <= DEF_LOW_BW;
        mute_en_reg    <= DEF_AUTO_MUTE;
        den_reg        <= '{DEF_DEN_LO, DEF_DEN_MID, DEF_DEN_HI};
      end else if (link.wr_en) begin
        case (link.wr_addr)
          REG_SOFT_RESET: soft_reset_reg <= link.wr_data;     // [R10]
          REG_CP_CURRENT: cp_reg         <= link.wr_data;     // [R1]
          REG_DSM_CFG:    dsm_reg        <= link.wr_data;     // [R14] [R15]
          REG_LF_R2:      lf_reg[0]      <= link.wr_data;     // [R2]
          REG_LF_C1:      lf_reg[1]      <= link.wr_data;
          REG_LF_R3:      lf_reg[2]      <= link.wr_data;
          REG_LF_C3:      lf_reg[3]      <= link.wr_data;
          REG_LOOP_ORDER: order_reg      <= link.wr_data;
          REG_LOW_BW:     lowbw_reg      <= link.wr_data;
          REG_AUTO_MUTE:  mute_en_reg    <= link.wr_data;
          REG_DEN_LO:     den_reg[0]     <= link.wr_data;     // [R17]
          REG_DEN_MID:    den_reg[1]     <= link.wr_data;
          REG_DEN_HI:     den_reg[2]     <= link.wr_data;
          default:        ;
        endcase
      end
    end
  end

  // read port answers one cycle after the address is sampled
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else if (clk_en_i) begin
      rd_valid_reg <= 1'b1;
      case (link.rd_addr)
        REG_SOFT_RESET: rd_data_reg <= soft_reset_reg;
        REG_CP_CURRENT: rd_data_reg <= cp_reg;
        REG_DSM_CFG:    rd_data_reg <= dsm_reg;
        REG_LF_R2:      rd_data_reg <= lf_reg[0];
        REG_LF_C1:      rd_data_reg <= lf_reg[1];
        REG_LF_R3:      rd_data_reg <= lf_reg[2];
        REG_LF_C3:      rd_data_reg <= lf_reg[3];
        REG_LOOP_ORDER: rd_data_reg <= order_reg;
        REG_LOW_BW:     rd_data_reg <= lowbw_reg;
        REG_AUTO_MUTE:  rd_data_reg <= mute_en_reg;
        REG_DEN_LO:     rd_data_reg <= den_reg[0];
        REG_DEN_MID:    rd_data_reg <= den_reg[1];
        REG_DEN_HI:     rd_data_reg <= {2'b00, den_reg[2][5:0]};
        default:        rd_data_reg <= 8'h00;
      endcase
    end
  end
  assign link.rd_data  = rd_data_reg;
  assign link.rd_valid = rd_valid_reg;

  // registered outputs; zero denominator is held at one to keep divide legal
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      charge_pump_current_sel_o <= DEF_CP_CURRENT[3:0];
      loop_filter_mode_bit_o    <= 1'b0;
      lf_r2_o                   <= DEF_LF;
      lf_c1_o                   <= DEF_LF;
      lf_r3_o                   <= DEF_LF;
      lf_c3_o                   <= DEF_LF;
      loop_order_cfg_o          <= DEF_LOOP_ORDER[2:0];
      low_bandwidth_ctrl_o      <= DEF_LOW_BW[0];
      modulator_order_sel_o     <= DEF_DSM_CFG[1:0];
      dither_mode_sel_o         <= DEF_DSM_CFG[3:2];
      fraction_denominator_o    <= 22'h00_0001;
      output_mute_o             <= DEF_AUTO_MUTE;
      vco_cal_busy_o            <= 1'b0;
      lock_enable_o             <= 1'b0;
      pll_ready_o               <= 1'b0;
    end else if (clk_en_i) begin
      charge_pump_current_sel_o <= cp_reg[3:0];                 // [R1]
      loop_filter_mode_bit_o    <= lf_reg[2][LF_MODE_POS];       // [R3] [R4]
      lf_r2_o                   <= lf_reg[0];                   // [R2]
      lf_c1_o                   <= lf_reg[1];
      lf_r3_o                   <= lf_reg[2];
      lf_c3_o                   <= lf_reg[3];
      loop_order_cfg_o          <= order_reg[2:0];
      low_bandwidth_ctrl_o      <= lowbw_reg[LOW_BW_POS];       // [R5]
      modulator_order_sel_o     <= dsm_reg[1:0];                // [R14]
      dither_mode_sel_o         <= dsm_reg[3:2];                // [R15]
      fraction_denominator_o    <= (den_raw == 22'h0) ? 22'h00_0001 : den_raw; // [R17]
      // muted from reset until lock follows a finished calibration
      output_mute_o             <= (state_next == ST_RUN) ? 8'h00 : mute_en_reg; // [R12] [R19]
      vco_cal_busy_o            <= (state_next == ST_CAL);
      lock_enable_o             <= (state_next == ST_LOCK) || (state_next == ST_RUN);
      pll_ready_o               <= (state_next == ST_RUN);
    end
  end
endmodule : plrc_device
`default_nettype wire

/* plrc_host.sv */
// host end: drives power-down pin and soft reset sequence, forwards user writes
`timescale 1ns/1ps
`default_nettype none
module plrc_host
  import plrc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  // user side
  input  wire logic       pin_powerdown_i,
  input  wire logic       soft_reset_req_i,
  input  wire logic       wr_req_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [7:0] rd_addr_i,
  output logic [7:0]      rd_data_o,
  output logic            busy_o,
  // link
  plrc_link_if.host       link
);
  plrc_hstate_t hs_reg;
  logic         pin_reg;
  logic         wr_en_reg;
  logic [7:0]   wr_addr_reg;
  logic [7:0]   wr_data_reg;
  logic [7:0]   rd_addr_reg;

  // soft reset: bit written low, then high on the next cycle [R10]
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_reg      <= HS_IDLE;
      pin_reg     <= 1'b1;
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      rd_data_o   <= 8'h00;
      busy_o      <= 1'b0;
    end else if (clk_en_i) begin
      pin_reg     <= ~pin_powerdown_i;
      rd_addr_reg <= rd_addr_i;
      rd_data_o   <= link.rd_data;
      wr_en_reg   <= 1'b0;
      case (hs_reg)
        HS_IDLE: begin
          busy_o <= 1'b0;
          if (soft_reset_req_i) begin
            wr_en_reg   <= 1'b1;
            wr_addr_reg <= REG_SOFT_RESET;
            wr_data_reg <= 8'h00;
            busy_o      <= 1'b1;
            hs_reg      <= HS_WRITE;
          end else if (wr_req_i) begin
            wr_en_reg   <= 1'b1;
            wr_addr_reg <= wr_addr_i;
            wr_data_reg <= wr_data_i;
          end
        end
        HS_WRITE: begin
          wr_en_reg   <= 1'b1;
          wr_addr_reg <= REG_SOFT_RESET;
          wr_data_reg <= DEF_SOFT_RESET;
          hs_reg      <= HS_WAIT;
        end
        HS_WAIT: begin
          busy_o <= 1'b0;
          hs_reg <= HS_IDLE;
        end
        default: hs_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.powerdown_n_pin = pin_reg;
  assign link.wr_en           = wr_en_reg;
  assign link.wr_addr         = wr_addr_reg;
  assign link.wr_data         = wr_data_reg;
  assign link.rd_addr         = rd_addr_reg;
endmodule : plrc_host
`default_nettype wire

/* plrc_asserts.sv */
// checker: sequencing and link relations between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module plrc_asserts
  import plrc_pkg::*;
#(
  parameter int RESET_TIMER_CYCLES = RESET_TIMER_CYC
) (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // link
  input wire logic       powerdown_n_pin,
  input wire logic       wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // device status
  input wire logic       supply_ok_i,
  input wire logic       pll_locked_i,
  input wire logic [7:0] output_mute_o,
  input wire logic       vco_cal_busy_o,
  input wire logic       lock_enable_o,
  input wire logic       pll_ready_o
);
  localparam int PIN_MAX = 300;
  int idle_cnt;
  int cal_cnt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // idle covers reset, load and stabilisation, so it bounds the timer from below
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt <= 0;
      cal_cnt  <= 0;
    end else begin
      idle_cnt <= (vco_cal_busy_o || lock_enable_o) ? 0 : idle_cnt + 1;
      cal_cnt  <= vco_cal_busy_o ? cal_cnt + 1 : 0;
    end
  end
  sequence s_soft_low;
    wr_en && wr_addr == REG_SOFT_RESET && wr_data == 8'h00;
  endsequence
  sequence s_pin_up;
    $rose(powerdown_n_pin) ##1 (powerdown_n_pin && supply_ok_i) [*8];
  endsequence
  sequence s_dsm_wr;
    pll_ready_o && wr_en && wr_addr == REG_DSM_CFG;
  endsequence
  a_mute_during_cal: assert property (vco_cal_busy_o |-> output_mute_o == 8'hFF)
    else $error("outputs not muted while calibrating");
  a_mute_until_ready: assert property (!pll_ready_o |-> output_mute_o == 8'hFF)
    else $error("outputs released before ready");
  a_ready_after_lock: assert property ($rose(pll_ready_o) |-> $past(pll_locked_i))
    else $error("ready raised without lock");
  a_timer_before_cal: assert property ($rose(vco_cal_busy_o) |->
    idle_cnt >= RESET_TIMER_CYCLES && $past(supply_ok_i))
    else $error("calibration began before timer or supply good");
  a_cal_then_lock: assert property ($fell(vco_cal_busy_o) && cal_cnt >= CAL_CYC |-> lock_enable_o)
    else $error("no lock phase after calibration");
  a_cal_length: assert property ($fell(vco_cal_busy_o) && lock_enable_o |->
    cal_cnt >= CAL_CYC && cal_cnt <= CAL_CYC + 1)
    else $error("calibration length wrong");
  a_pin_low_reset: assert property (!powerdown_n_pin [*6] |-> !vco_cal_busy_o && !pll_ready_o)
    else $error("pin low did not hold reset");
  a_soft_low_reset: assert property (wr_en && wr_addr == REG_SOFT_RESET &&
    !wr_data[SOFT_RESET_POS] |-> ##[1:3] !pll_ready_o && !vco_cal_busy_o)
    else $error("soft bit low did not reset");
  a_soft_pair: assert property (s_soft_low |=>
    wr_en && wr_addr == REG_SOFT_RESET && wr_data == DEF_SOFT_RESET)
    else $error("soft reset not followed by restore write");
  a_pin_exit_cal: assert property (s_pin_up |-> ##[1:PIN_MAX] vco_cal_busy_o)
    else $error("no calibration after pin release");
  a_dsm_readback: assert property (s_dsm_wr ##1 (rd_addr == REG_DSM_CFG) [*2] |->
    rd_data == $past(wr_data, 2))
    else $error("modulator register readback wrong");
endmodule : plrc_asserts
`default_nettype wire

/* testbench.sv */
// testbench: host and device ends joined by the link, random and corner stimulus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import plrc_pkg::*;
  localparam int TMR = 20;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        supply_ok_i = 1'b1;
  logic        pll_locked_i = 1'b1;
  logic        pin_pd = 1'b0;
  logic        soft_req = 1'b0;
  logic        wr_req = 1'b0;
  logic [7:0]  wa = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  ra = 8'h00;
  logic [7:0]  rdat, r2, c1, r3, c3, mute;
  logic [3:0]  cp;
  logic [2:0]  lorder;
  logic [1:0]  mord, dith;
  logic [1:0]  dsel;
  logic [21:0] fraction_denominator;
  logic        hbusy, lf_mode, lowbw, cal_busy, lock_en, ready;
  logic [31:0] lfsr = 32'h0001_75F6;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  plrc_link_if plrc_link_if_i ();
  plrc_host plrc_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .pin_powerdown_i(pin_pd), .soft_reset_req_i(soft_req), .wr_req_i(wr_req),
    .wr_addr_i(wa), .wr_data_i(wd), .rd_addr_i(ra), .rd_data_o(rdat), .busy_o(hbusy),
    .link(plrc_link_if_i));
  plrc_device #(.RESET_TIMER_CYCLES(TMR)) plrc_device_i (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .clk_en_i(clk_en_i), .link(plrc_link_if_i), .supply_ok_i(supply_ok_i),
    .pll_locked_i(pll_locked_i), .charge_pump_current_sel_o(cp), .loop_filter_mode_bit_o(lf_mode),
    .lf_r2_o(r2), .lf_c1_o(c1), .lf_r3_o(r3), .lf_c3_o(c3), .loop_order_cfg_o(lorder),
    .low_bandwidth_ctrl_o(lowbw), .modulator_order_sel_o(mord), .dither_mode_sel_o(dith),
    .fraction_denominator_o(fraction_denominator), .output_mute_o(mute), .vco_cal_busy_o(cal_busy),
    .lock_enable_o(lock_en), .pll_ready_o(ready));
  plrc_asserts #(.RESET_TIMER_CYCLES(TMR)) plrc_asserts_i (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .powerdown_n_pin(plrc_link_if_i.powerdown_n_pin),
    .wr_en(plrc_link_if_i.wr_en), .wr_addr(plrc_link_if_i.wr_addr),
    .wr_data(plrc_link_if_i.wr_data), .rd_addr(plrc_link_if_i.rd_addr),
    .rd_data(plrc_link_if_i.rd_data), .supply_ok_i(supply_ok_i), .pll_locked_i(pll_locked_i),
    .output_mute_o(mute), .vco_cal_busy_o(cal_busy), .lock_enable_o(lock_en),
    .pll_ready_o(ready));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  // a zero denominator is shown as one, so the divider never sees zero
  function automatic logic [21:0] exp_den(input logic [7:0] lo, mid, hi);
    logic [21:0] d;
    d = {hi[5:0], mid, lo};
    return (d == 22'h00_0000) ? 22'h00_0001 : d;
  endfunction : exp_den
  // host keeps dither off unless the denominator is large and divisible by 2 or 3
  function automatic logic [1:0] rec_dither(input logic [21:0] d, input logic [1:0] want);
    return (d > DEN_DITHER_GOOD && (d % 22'h00_0002 == 22'h00_0000 ||
            d % 22'h00_0003 == 22'h00_0000)) ? want : 2'h0;
  endfunction : rec_dither
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wa = a;
    wd = d;
    wr_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    tick(4);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ra = a;
    tick(6);
    chk("rd_data", rdat, exp);
    chk("rd_valid", plrc_link_if_i.rd_valid, 1'b1);
  endtask : rd
  // bounded wait: which=1 waits for ready, which=0 for calibration
  task automatic wait_for(input bit which);
    int n;
    n = 0;
    while ((which ? ready : cal_busy) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      chk("wait", 0, 1);
      report_and_stop();
    end
  endtask : wait_for
  task automatic soft_reset();
    soft_req = 1'b1;
    tick(1);
    chk("busy", hbusy, 1'b1);
    soft_req = 1'b0;
    tick(4);
    chk("ready", ready, 1'b0);
    chk("busy_end", hbusy, 1'b0);
  endtask : soft_reset

  initial begin
    tick(16);
    rst_i = 1'b0;
    tick(4);
    chk("cp", cp, DEF_CP_CURRENT[3:0]);
    chk("mord", mord, DEF_DSM_CFG[1:0]);
    chk("dith", dith, DEF_DSM_CFG[3:2]);
    chk("order", lorder, DEF_LOOP_ORDER[2:0]);
    chk("den", fraction_denominator, 22'h00_0001);
    chk("mute", mute, 8'hFF);
    wait_for(1'b1);
    chk("mute", mute, 8'h00);
    $display("test power_up done");
    ra = REG_DSM_CFG;
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      wr(REG_CP_CURRENT, {4'h0, lfsr[3:0]});
      chk("cp", cp, lfsr[3:0]);
      wr(REG_DSM_CFG, {4'h0, lfsr[7:4]});
      chk("mord", mord, lfsr[5:4]);
      chk("dith", dith, lfsr[7:6]);
      wr(REG_LF_R2, lfsr[15:8]);
      wr(REG_LF_C1, lfsr[23:16]);
      wr(REG_LF_R3, lfsr[31:24]);
      wr(REG_LF_C3, lfsr[7:0]);
      chk("lf", {r2, c1, r3, c3}, {lfsr[15:8], lfsr[23:16], lfsr[31:24], lfsr[7:0]});
      chk("lf_mode", lf_mode, lfsr[24]);
      wr(REG_DEN_LO, lfsr[7:0]);
      wr(REG_DEN_MID, lfsr[15:8]);
      wr(REG_DEN_HI, lfsr[31:24]);
      chk("den", fraction_denominator, exp_den(lfsr[7:0], lfsr[15:8], lfsr[31:24]));
      dsel = rec_dither(exp_den(lfsr[7:0], lfsr[15:8], lfsr[31:24]), lfsr[7:6]);
      wr(REG_DSM_CFG, {4'h0, dsel, lfsr[5:4]});
      chk("dith_rec", dith, dsel);
    end
    wr(REG_LF_R3, 8'h00);
    wr(REG_LOOP_ORDER, {5'h00, LOOP_ORDER_SECOND});
    chk("integer", {lf_mode, lorder}, {1'b0, LOOP_ORDER_SECOND});
    wr(REG_LF_R3, 8'h01);
    wr(REG_LOOP_ORDER, {5'h00, LOOP_ORDER_THIRD});
    chk("fractional", {lf_mode, lorder}, {1'b1, LOOP_ORDER_THIRD});
    wr(REG_LOW_BW, 8'h00);
    chk("lowbw", lowbw, 1'b0);
    // with the enable low neither end may take the write
    clk_en_i = 1'b0;
    wr(REG_LOW_BW, 8'h01);
    clk_en_i = 1'b1;
    chk("frozen", lowbw, 1'b0);
    wr(REG_DEN_LO, 8'hFF);
    wr(REG_DEN_MID, 8'hFF);
    wr(REG_DEN_HI, 8'h3F);
    chk("den_max", fraction_denominator, DEN_MAX);
    wr(REG_DEN_HI, 8'h00);
    wr(REG_DEN_MID, 8'h00);
    wr(REG_DEN_LO, DEN_DITHER_MIN[7:0] - 8'h01);
    dsel = rec_dither(exp_den(DEN_DITHER_MIN[7:0] - 8'h01, 8'h00, 8'h00), 2'h3);
    wr(REG_DSM_CFG, {4'h0, dsel, 2'h3});
    chk("dith_small", {dith, fraction_denominator}, {2'h0, DEN_DITHER_MIN - 22'h00_0001});
    wr(8'h01, 8'h5A);
    rd(8'h01, 8'h00);
    rd(REG_SOFT_RESET, DEF_SOFT_RESET);
    rd(REG_AUTO_MUTE, DEF_AUTO_MUTE);
    $display("test registers done");
    wr(REG_CP_CURRENT, 8'h0B);
    soft_reset();
    wait_for(1'b0);
    tick(10);
    soft_reset();
    chk("cal_busy", cal_busy, 1'b0);
    wait_for(1'b1);
    chk("cp_kept", cp, 4'hB);
    chk("lowbw_kept", lowbw, 1'b0);
    rd(REG_SOFT_RESET, DEF_SOFT_RESET);
    $display("test soft_reset done");
    pin_pd = 1'b1;
    supply_ok_i = 1'b0;
    tick(10);
    chk("pin_reset", {ready, cal_busy}, 2'b00);
    pin_pd = 1'b0;
    tick(TMR + 40);
    chk("no_cal", cal_busy, 1'b0);
    chk("cp_reload", cp, DEF_CP_CURRENT[3:0]);
    pll_locked_i = 1'b0;
    supply_ok_i = 1'b1;
    wait_for(1'b0);
    tick(CAL_CYC + 10);
    chk("lock_en", lock_en, 1'b1);
    chk("mute_lock", {ready, mute}, {1'b0, 8'hFF});
    pll_locked_i = 1'b1;
    wait_for(1'b1);
    pin_pd = 1'b1;
    tick(8);
    pin_pd = 1'b0;
    wait_for(1'b1);
    chk("mute_run", mute, 8'h00);
    $display("test powerdown done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
